// *** verilog/pds_pkg.sv ***
// Behaviour
// - timing starts once all grouped rails regulate
// - delay code picks 2.5 to 100 ms
// - delay ignored when output neither power good nor termination enable
// - writing one starts shutdown, zero does nothing
// - shutdown returns every register to reset
// - shutdown bit self-clears, reads back zero
// - shutdown write is never acknowledged
// - first regulator sleep code in bits 7:1
// - first regulator uses sleep code when enabled
// - sleep pin fixed per regulator at build
// - second regulator sleep code in bits 7:1
// - second regulator uses sleep code when enabled
package pds_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_PG_DELAY = 8'h43;
  localparam logic [7:0] OFS_SHUTDOWN = 8'h91;
  localparam logic [7:0] OFS_SLEEP_ONE = 8'h92;
  localparam logic [7:0] OFS_SLEEP_TWO = 8'h93;
  localparam int CODE_W = 7;
  localparam int DLY_W = 3;
  localparam int SLEEP_EN_BIT = 0;
  localparam int CODE_LSB = 1;
  localparam int SHUTDOWN_BIT = 0;
  localparam logic [DLY_W-1:0] RST_PG_DELAY = 3'h0;
  localparam logic [CODE_W-1:0] RST_CODE = 7'h00;
  localparam logic RST_SLEEP_EN = 1'b0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int PG_TICK_US = 500;
  localparam int PG_TICK_CYCLES = PG_TICK_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned PG_DELAY_US [8] =
    '{2500, 5000, 10000, 15000, 20000, 50000, 75000, 100000};
  localparam int TICK_W = 17;
  localparam int TCNT_W = 8;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACKW, ST_ACK, ST_RDATA, ST_MACK
  } pds_state_e;

  typedef struct packed {
    pds_state_e fsm;
    pds_state_e after;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic oe;
    logic sd;
    logic [DLY_W-1:0] pg_delay;
    logic [CODE_W-1:0] s1_code;
    logic s1_en;
    logic [CODE_W-1:0] s2_code;
    logic s2_en;
    logic [CODE_W-1:0] code1;
    logic [CODE_W-1:0] code2;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] flt;
    logic [3:0] fltp;
  } pds_main_s;

  localparam pds_main_s MAIN_RST = '{
    fsm: ST_IDLE, after: ST_IDLE, cnt: 3'h0, shift: 8'h00, ptr: 8'h00,
    oe: 1'b0, sd: 1'b0, pg_delay: RST_PG_DELAY, s1_code: RST_CODE,
    s1_en: RST_SLEEP_EN, s2_code: RST_CODE, s2_en: RST_SLEEP_EN,
    code1: RST_CODE, code2: RST_CODE, sy1: 4'hF, sy2: 4'hF, sy3: 4'hF,
    flt: 4'hF, fltp: 4'hF};

  typedef struct packed {
    logic pg;
    logic [TICK_W-1:0] pre;
    logic [TCNT_W-1:0] ticks;
  } pds_timer_s;

endpackage

// *** verilog/pds_pg_timer.sv ***
`timescale 1ns/1ps
module pds_pg_timer #(
  parameter int TICK_CYCLES = pds_pkg::PG_TICK_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, low
  input wire logic clr, // shutdown clear
  input wire logic rails_ok, // grouped rails regulate
  input wire logic used, // delay applies
  input wire logic [pds_pkg::DLY_W-1:0] code, // delay select
  output logic pg // power good
);
  import pds_pkg::*;

  pds_timer_s st;
  pds_timer_s n;
  logic [TCNT_W-1:0] target;

  // ****************************************
  // delay counter
  // ****************************************
  // prescaled tick counter, restarts whenever rails drop
  always_comb
  begin
    n = st;
    target = TCNT_W'(PG_DELAY_US[code] / PG_TICK_US);
    if (clr || !rails_ok)
    begin
      n = '0;
    end
    else if (!used)
    begin
      n.pg = 1'b1;
    end
    else if (!st.pg)
    begin
      if (st.pre == TICK_W'(TICK_CYCLES - 1))
      begin
        n.pre = '0;
        n.ticks = st.ticks + 8'h01;
        n.pg = (st.ticks + 8'h01) >= target;
      end
      else
      begin
        n.pre = st.pre + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= n;
  end

  assign pg = st.pg;

  // ****************************************
  // checks
  // ****************************************
  // cycles since rails came up, read only by checks
  logic [31:0] okcnt;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      okcnt <= '0;
    else if (clr || !rails_ok)
      okcnt <= '0;
    else
      okcnt <= okcnt + 32'h1;
  end

  property p_rail_drop;
    @(posedge clk) disable iff (!rst_b)
    !rails_ok |=> !pg;
  endproperty
  a_rail_drop: assert property (p_rail_drop)
    else $error("power good held with rails down");

  property p_delay_len;
    @(posedge clk) disable iff (!rst_b)
    (!st.pg && n.pg && used) |->
      (okcnt == 32'(target) * 32'(TICK_CYCLES) - 32'h1);
  endproperty
  a_delay_len: assert property (p_delay_len)
    else $error("power good delay length wrong");

  property p_no_delay;
    @(posedge clk) disable iff (!rst_b)
    (rails_ok && !used && !clr) |=> pg;
  endproperty
  a_no_delay: assert property (p_no_delay)
    else $error("delay applied while unused");

  c_pg_rise: cover property (@(posedge clk) disable iff (!rst_b)
    used ##1 $rose(pg));

endmodule // pds_pg_timer

// *** verilog/pds_regs.sv ***
`timescale 1ns/1ps
module pds_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary bus address
  parameter logic FIRST_PIN_SEL = 1'b0, // 0 third, 1 sixth input
  parameter logic SECOND_PIN_SEL = 1'b1, // 0 third, 1 sixth input
  parameter int PG_TICK_CYCLES = pds_pkg::PG_TICK_CYCLES // per 0.5 ms
) (
  input wire logic SYS_CLK, // 200 MHz clock
  input wire logic RST_B, // async reset, low
  input wire logic SCL_IN, // serial clock pin
  input wire logic SDA_IN, // serial data pin level
  output logic SDA_OUT, // serial data drive value
  output logic SDA_OE, // high pulls data low
  input wire logic THIRD_CONTROL_INPUT, // sleep pin, low sleeps
  input wire logic SIXTH_CONTROL_INPUT, // sleep pin, low sleeps
  input wire logic [pds_pkg::CODE_W-1:0] FIRST_STEPDOWN_NORMAL_CODE, // norm
  input wire logic [pds_pkg::CODE_W-1:0] SECOND_STEPDOWN_NORMAL_CODE, // nrm
  output logic [pds_pkg::CODE_W-1:0] FIRST_STEPDOWN_CODE, // applied code
  output logic [pds_pkg::CODE_W-1:0] SECOND_STEPDOWN_CODE, // applied code
  input wire logic RAILS_IN_RANGE, // grouped rails regulate
  input wire logic THIRD_OUTPUT_IS_GOOD, // output acts as power good
  input wire logic THIRD_OUTPUT_TERM_EN, // output enables termination
  output logic THIRD_GENERAL_OUTPUT, // delayed power good
  output logic EMERGENCY_SHUTDOWN // one-cycle shutdown pulse
);
  import pds_pkg::*;

  pds_main_s st;
  pds_main_s n;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda;
  logic [7:0] got;
  logic [7:0] rd;
  logic pin1;
  logic pin2;

  // ****************************************
  // pin filtering and edges
  // ****************************************
  // bit 0 clock, bit 1 data, bit 2 third input, bit 3 sixth input
  always_comb
  begin
    sda = st.flt[1];
    scl_rise = st.flt[0] && !st.fltp[0];
    scl_fall = !st.flt[0] && st.fltp[0];
    bus_start = st.flt[0] && st.fltp[0] && !st.flt[1] && st.fltp[1];
    bus_stop = st.flt[0] && st.fltp[0] && st.flt[1] && !st.fltp[1];
    got = {st.shift[6:0], sda};
    pin1 = FIRST_PIN_SEL ? st.flt[3] : st.flt[2];
    pin2 = SECOND_PIN_SEL ? st.flt[3] : st.flt[2];
  end

  // ****************************************
  // read mux
  // ****************************************
  // reserved bits and unmapped offsets read zero
  always_comb
  begin
    case (st.ptr)
      OFS_PG_DELAY: rd = {5'h00, st.pg_delay};
      OFS_SHUTDOWN: rd = 8'h00;
      OFS_SLEEP_ONE: rd = {st.s1_code, st.s1_en};
      OFS_SLEEP_TWO: rd = {st.s2_code, st.s2_en};
      default: rd = READ_UNMAPPED;
    endcase
  end

  // ****************************************
  // bus engine and registers
  // ****************************************
  // ack driven on clock fall, data sampled on clock rise
  always_comb
  begin
    n = st;
    n.sd = 1'b0;
    n.sy1 = {SIXTH_CONTROL_INPUT, THIRD_CONTROL_INPUT, SDA_IN, SCL_IN};
    n.sy2 = st.sy1;
    n.sy3 = st.sy2;
    n.flt = (st.sy2 & st.sy3) | (st.flt & (st.sy2 ^ st.sy3));
    n.fltp = st.flt;
    // sleep code only while enabled and assigned pin low
    n.code1 = (st.s1_en && !pin1) ? st.s1_code
                                  : FIRST_STEPDOWN_NORMAL_CODE;
    n.code2 = (st.s2_en && !pin2) ? st.s2_code
                                  : SECOND_STEPDOWN_NORMAL_CODE;
    if (bus_start)
    begin
      n.fsm = ST_ADDR;
      n.cnt = 3'h0;
      n.oe = 1'b0;
    end
    else if (bus_stop)
    begin
      n.fsm = ST_IDLE;
      n.oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st.fsm)
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          n.shift = got;
          n.cnt = st.cnt + 3'h1;
          if (st.cnt == BIT_LAST)
          begin
            n.fsm = ST_ACKW;
            n.after = ST_WDATA;
            case (st.fsm)
              ST_ADDR:
              begin
                if (got[7:1] != DEV_ADDR)
                  n.fsm = ST_IDLE;
                else if (got[0])
                  n.after = ST_RDATA;
                else
                  n.after = ST_REG;
              end
              ST_REG: n.ptr = got;
              default:
              begin
                // full byte in hand before shutdown, no ack
                if (st.ptr == OFS_SHUTDOWN && got[SHUTDOWN_BIT])
                begin
                  n.fsm = ST_IDLE;
                  n.sd = 1'b1;
                end
                else
                begin
                  case (st.ptr)
                    OFS_PG_DELAY: n.pg_delay = got[DLY_W-1:0];
                    OFS_SLEEP_ONE:
                    begin
                      n.s1_code = got[7:CODE_LSB];
                      n.s1_en = got[SLEEP_EN_BIT];
                    end
                    OFS_SLEEP_TWO:
                    begin
                      n.s2_code = got[7:CODE_LSB];
                      n.s2_en = got[SLEEP_EN_BIT];
                    end
                    default: ;
                  endcase
                  n.ptr = st.ptr + 8'h01;
                end
              end
            endcase
          end
        end
        ST_MACK:
        begin
          n.fsm = sda ? ST_IDLE : ST_ACK;
          n.after = ST_RDATA;
        end
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (st.fsm)
        ST_ACKW:
        begin
          n.fsm = ST_ACK;
          n.oe = 1'b1;
        end
        ST_ACK:
        begin
          n.fsm = st.after;
          n.oe = 1'b0;
          n.cnt = 3'h0;
          if (st.after == ST_RDATA)
          begin
            n.shift = rd;
            n.oe = !rd[7];
          end
        end
        ST_RDATA:
        begin
          if (st.cnt == BIT_LAST)
          begin
            n.oe = 1'b0;
            n.fsm = ST_MACK;
            n.ptr = st.ptr + 8'h01;
          end
          else
          begin
            n.shift = {st.shift[6:0], 1'b0};
            n.oe = !st.shift[6];
            n.cnt = st.cnt + 3'h1;
          end
        end
        default: ;
      endcase
    end
    // shutdown pulse wipes the whole controller next edge
    if (st.sd)
      n = MAIN_RST;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
      st <= MAIN_RST;
    else
      st <= n;
  end

  // ****************************************
  // power good delay
  // ****************************************
  pds_pg_timer #(
    .TICK_CYCLES(PG_TICK_CYCLES)
  ) u_timer (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .clr(st.sd),
    .rails_ok(RAILS_IN_RANGE),
    .used(THIRD_OUTPUT_IS_GOOD || THIRD_OUTPUT_TERM_EN),
    .code(st.pg_delay),
    .pg(THIRD_GENERAL_OUTPUT)
  );

  // outputs from state flops, data drive value tied low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = st.oe;
  assign FIRST_STEPDOWN_CODE = st.code1;
  assign SECOND_STEPDOWN_CODE = st.code2;
  assign EMERGENCY_SHUTDOWN = st.sd;

  // ****************************************
  // checks
  // ****************************************
  property p_sd_nack;
    @(posedge SYS_CLK) disable iff (!RST_B)
    st.sd |-> !st.oe ##1 (!st.oe) [*3];
  endproperty
  a_sd_nack: assert property (p_sd_nack)
    else $error("shutdown write was acknowledged");

  property p_sd_wipe;
    @(posedge SYS_CLK) disable iff (!RST_B)
    st.sd |=> (st.s1_code == RST_CODE && !st.s1_en && !st.s2_en &&
      st.pg_delay == RST_PG_DELAY && st.ptr == 8'h00 && !st.sd);
  endproperty
  a_sd_wipe: assert property (p_sd_wipe)
    else $error("registers survived shutdown");

  property p_sd_reads_zero;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (st.ptr == OFS_SHUTDOWN) |-> (rd == 8'h00);
  endproperty
  a_sd_reads_zero: assert property (p_sd_reads_zero)
    else $error("shutdown bit reads nonzero");

  property p_zero_no_action;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (scl_rise && !bus_start && !bus_stop && st.fsm == ST_WDATA &&
      st.cnt == BIT_LAST && st.ptr == OFS_SHUTDOWN && !sda)
      |=> (!st.sd && st.fsm == ST_ACKW);
  endproperty
  a_zero_no_action: assert property (p_zero_no_action)
    else $error("zero write acted on shutdown");

  property p_full_byte;
    @(posedge SYS_CLK) disable iff (!RST_B)
    st.sd |-> ($past(st.fsm) == ST_WDATA && $past(st.cnt) == BIT_LAST);
  endproperty
  a_full_byte: assert property (p_full_byte)
    else $error("shutdown before full byte");

  property p_first_normal;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (!st.s1_en && !st.sd) |=>
      (FIRST_STEPDOWN_CODE == $past(FIRST_STEPDOWN_NORMAL_CODE));
  endproperty
  a_first_normal: assert property (p_first_normal)
    else $error("first regulator left normal code");

  property p_second_sleep;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (st.s2_en && !pin2 && !st.sd) |=>
      (SECOND_STEPDOWN_CODE == $past(st.s2_code));
  endproperty
  a_second_sleep: assert property (p_second_sleep)
    else $error("second regulator missed sleep code");

  c_shutdown: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    st.sd);
  c_read: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    st.fsm == ST_RDATA ##[1:1000] st.fsm == ST_MACK);
  c_sleep: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    st.s1_en && !pin1);

endmodule // pds_regs

// *** test/pds_host.sv ***
`timescale 1ns/1ps
module pds_host (
  input wire logic clk, // system clock
  input wire logic sda, // resolved data wire
  output logic scl, // serial clock drive
  output logic sda_low // high pulls data low
);
  // ****************************************
  // idle bus: clock stands high, data released
  // ****************************************
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one phase of the bus, 10 system clocks
  task automatic hold();
    repeat (10) @(negedge clk);
  endtask

  // start or repeated start
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask

  // stop, leaves bus idle
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask

  // one bit out, wire level sampled at end of high phase
  task automatic bitx(input logic b, output logic r);
    sda_low = ~b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
    hold();
  endtask

  // byte msb first, then ninth bit
  task automatic xfer(input logic [7:0] tx, input logic ninth,
                      output logic [7:0] rx, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(tx[i], rx[i]);
    end
    bitx(ninth, b);
    ack = ~b;
  endtask
endmodule // pds_host

// *** test/pds_regs_tb_top.sv ***
`timescale 1ns/1ps
module pds_regs_tb_top;
  import pds_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary bus address
  logic sys_clk, rst_b, sda_out, sda_oe, third, sixth;
  logic rails, good, term, pg, sd, scl, sda_low;
  logic [6:0] n1, n2, c1, c2;
  wire logic sda_wire = ~(sda_low | sda_oe); // pull-up wire
  int failures, compares, pulses;

  // ****************************************
  // design and bus host
  // ****************************************
  pds_regs #(.DEV_ADDR(ADDR), .PG_TICK_CYCLES(10)) u_pds_regs (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .THIRD_CONTROL_INPUT(third),
    .SIXTH_CONTROL_INPUT(sixth), .FIRST_STEPDOWN_NORMAL_CODE(n1),
    .SECOND_STEPDOWN_NORMAL_CODE(n2), .FIRST_STEPDOWN_CODE(c1),
    .SECOND_STEPDOWN_CODE(c2), .RAILS_IN_RANGE(rails),
    .THIRD_OUTPUT_IS_GOOD(good), .THIRD_OUTPUT_TERM_EN(term),
    .THIRD_GENERAL_OUTPUT(pg), .EMERGENCY_SHUTDOWN(sd));
  pds_host u_pds_host (.clk(sys_clk), .sda(sda_wire), .scl(scl),
    .sda_low(sda_low));

  // clock and shutdown pulse count
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (sd === 1'b1) pulses <= pulses + 1;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, dat, output logic ack);
    logic [7:0] rx;
    logic a;
    u_pds_host.start();
    u_pds_host.xfer({ADDR, 1'b0}, 1'b1, rx, a);
    u_pds_host.xfer(ofs, 1'b1, rx, a);
    u_pds_host.xfer(dat, 1'b1, rx, ack);
    u_pds_host.stop();
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
    logic [7:0] rx;
    logic a;
    u_pds_host.start();
    u_pds_host.xfer({ADDR, 1'b0}, 1'b1, rx, a);
    u_pds_host.xfer(ofs, 1'b1, rx, a);
    u_pds_host.start();
    u_pds_host.xfer({ADDR, 1'b1}, 1'b1, rx, a);
    u_pds_host.xfer(8'hFF, 1'b1, dat, a);
    u_pds_host.stop();
  endtask

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] v;
    logic [7:0] ofs [5] = '{OFS_PG_DELAY, OFS_SHUTDOWN, OFS_SLEEP_ONE,
                            OFS_SLEEP_TWO, 8'h44};
    foreach (ofs[i])
    begin
      rd(ofs[i], v);
      chk("reset read", 8'h00, v);
    end
    chk("code one", {1'b0, n1}, {1'b0, c1});
    chk("drive value", 8'h00, {7'h00, sda_out});
    $display("test reset done");
  endtask

  task automatic t_sleep();
    logic [7:0] v;
    logic a;
    wr(OFS_SLEEP_ONE, 8'hAB, a);
    wr(OFS_SLEEP_TWO, 8'hCD, a);
    rd(OFS_SLEEP_ONE, v);
    chk("sleep one reg", 8'hAB, v);
    rd(OFS_SLEEP_TWO, v);
    chk("sleep two reg", 8'hCD, v);
    chk("code one awake", {1'b0, n1}, {1'b0, c1});
    third = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("code one asleep", 8'h55, {1'b0, c1});
    chk("code two awake", {1'b0, n2}, {1'b0, c2});
    sixth = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("code two asleep", 8'h66, {1'b0, c2});
    wr(OFS_SLEEP_ONE, 8'hAA, a);
    chk("code one disabled", {1'b0, n1}, {1'b0, c1});
    third = 1'b1;
    sixth = 1'b1;
    $display("test sleep done");
  endtask

  task automatic t_delay();
    logic [7:0] v;
    logic a;
    int n, lim;
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_PG_DELAY, {5'h1F, i[2:0]}, a);
      rd(OFS_PG_DELAY, v);
      chk("delay reg", {5'h00, i[2:0]}, v);
      rails = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk("good low", 8'h00, {7'h00, pg});
      rails = 1'b1;
      lim = PG_DELAY_US[i] / PG_TICK_US * 10;
      n = 0;
      while (pg !== 1'b1 && n < 2100)
      begin
        @(negedge sys_clk);
        n++;
      end
      chk("delay in range", 8'h01, {7'h00, n >= lim && n <= lim + 2});
    end
    good = 1'b0;
    rails = 1'b0;
    repeat (3) @(negedge sys_clk);
    rails = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("delay ignored", 8'h01, {7'h00, pg});
    term = 1'b1;
    rails = 1'b0;
    repeat (3) @(negedge sys_clk);
    rails = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("delay for term", 8'h00, {7'h00, pg});
    good = 1'b1;
    term = 1'b0;
    $display("test delay done");
  endtask

  task automatic t_shutdown();
    logic [7:0] v;
    logic a;
    wr(OFS_SLEEP_ONE, 8'hAB, a);
    wr(OFS_SHUTDOWN, 8'h00, a);
    chk("zero write ack", 8'h01, {7'h00, a});
    u_pds_host.start();
    u_pds_host.xfer({ADDR, 1'b0}, 1'b1, v, a);
    u_pds_host.xfer(OFS_SHUTDOWN, 1'b1, v, a);
    for (int i = 0; i < 4; i++) u_pds_host.bitx(1'b1, a);
    u_pds_host.stop();
    chk("no pulse yet", 8'h00, pulses[7:0]);
    wr(OFS_SHUTDOWN, 8'h01, a);
    chk("shutdown ack", 8'h00, {7'h00, a});
    chk("one pulse", 8'h01, pulses[7:0]);
    rd(OFS_SLEEP_ONE, v);
    chk("wiped reg", 8'h00, v);
    rd(OFS_SHUTDOWN, v);
    chk("bit cleared", 8'h00, v);
    $display("test shutdown done");
  endtask

  // two-byte write and two-byte read with host ack, pointer steps
  task automatic t_burst();
    logic [7:0] v;
    logic [7:0] w;
    logic a;
    u_pds_host.start();
    u_pds_host.xfer({ADDR, 1'b0}, 1'b1, v, a);
    u_pds_host.xfer(OFS_SLEEP_ONE, 1'b1, v, a);
    u_pds_host.xfer(8'h83, 1'b1, v, a);
    u_pds_host.xfer(8'h84, 1'b1, v, a);
    u_pds_host.stop();
    chk("burst write ack", 8'h01, {7'h00, a});
    u_pds_host.start();
    u_pds_host.xfer({ADDR, 1'b0}, 1'b1, v, a);
    u_pds_host.xfer(OFS_SLEEP_ONE, 1'b1, v, a);
    u_pds_host.start();
    u_pds_host.xfer({ADDR, 1'b1}, 1'b1, v, a);
    u_pds_host.xfer(8'hFF, 1'b0, v, a);
    u_pds_host.xfer(8'hFF, 1'b1, w, a);
    u_pds_host.stop();
    chk("burst read one", 8'h83, v);
    chk("burst read two", 8'h84, w);
    sixth = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("code one other pin", {1'b0, n1}, {1'b0, c1});
    chk("code two disabled", {1'b0, n2}, {1'b0, c2});
    third = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("code one burst", 8'h41, {1'b0, c1});
    third = 1'b1;
    sixth = 1'b1;
    $display("test burst done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    {failures, compares, pulses} = '0;
    rst_b = 1'b0;
    {third, sixth, rails, good, term} = 5'b11110;
    n1 = 7'h11;
    n2 = 7'h22;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (5) @(negedge sys_clk);
    t_reset();
    t_sleep();
    t_delay();
    t_shutdown();
    t_burst();
    end_of_test();
  end
  initial
  begin
    repeat (99000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
endmodule // pds_regs_tb_top
